// file: rtl/mops_top.v
`timescale 1ns/1ps
`include "mops_map.vh"
module mops_top (
	input  wire        clk,
	input  wire        rst_n,
	input  wire [7:0]  s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        runInput,
	input  wire        channelGateInput,
	input  wire [7:0]  progSelect,
	input  wire        chanDone,
	output reg         progStart,
	output reg  [7:0]  progChan,
	output reg         progActive,
	input  wire [7:0]  funcOut,
	input  wire [7:0]  busFuncOut,
	output reg  [7:0]  generalOutput,
	output reg  [7:0]  fieldbusOutput,
	input  wire        homeSensor,
	input  wire        limitSensor,
	input  wire        indexPulse,
	output wire        homeMoveReq,
	output wire        homeMoveDir,
	input  wire [21:0] position,
	input  wire        sensorFaultAlarm,
	input  wire        absolutePositionAlarm,
	input  wire        overspeedAlarm,
	output reg         softLimitHit,
	input  wire        overrideRequestInput,
	input  wire [15:0] cmdVel,
	output reg  [16:0] velOut
);
	// filtered pin inputs
	wire [7:0]  selF;        // channel select pins
	wire [5:0]  pinF;        // run, gate, sensors, index, override
	wire        runF   = pinF[0];
	wire        gateF  = pinF[1];
	wire        ovrF   = pinF[5];
	reg         runPrev;     // run edge detect

	// axi state
	reg         awHeld;      // write address captured
	reg  [7:0]  awAddrQ;     // captured write address
	reg         wHeld;       // write data captured
	reg  [31:0] wDataQ;      // captured write data
	reg  [3:0]  wStrbQ;      // captured strobes
	wire        doWrite = awHeld & wHeld & ~s_axi_bvalid;
	wire [31:0] mask = {{8{wStrbQ[3]}}, {8{wStrbQ[2]}}, {8{wStrbQ[1]}}, {8{wStrbQ[0]}}};

	// software state
	reg  [1:0]  seqOpt;      // program sequence option
	reg  [7:0]  forceEn;     // outputs under forcing
	reg  [7:0]  forceVal;    // forced levels
	reg  [2:0]  homeMode;    // home return mode
	reg         homeStart;   // one-cycle start
	reg  [21:0] limStart;    // forbidden span start
	reg  [21:0] limEnd;      // forbidden span end
	reg  [15:0] ovrRatio;    // override in 0.01 percent
	reg         teachRefused;// last teach refused
	reg         stepPending; // option 1 advance owed

	// merged write values
	wire [31:0] mergeOtp = ({10'h000, limStart} & ~mask) | (wDataQ & mask);
	wire [31:0] mergeEnd = ({10'h000, limEnd} & ~mask) | (wDataQ & mask);
	wire [31:0] mergeOvr = ({16'h0000, ovrRatio} & ~mask) | (wDataQ & mask);
	wire        alarmAny = sensorFaultAlarm | absolutePositionAlarm | overspeedAlarm;
	wire        wrTeach  = doWrite & (awAddrQ == `MOPS_A_TEACH) & wStrbQ[0];

	// home block
	wire        homeBusy;
	wire        homeDone;
	wire        homeErr;
	wire [21:0] homePos;

	assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
	assign s_axi_wready  = ~wHeld & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;

	mops_sync #(.W(8)) u_selSync (
		.clk   (clk),
		.rst_n (rst_n),
		.din   (progSelect),
		.dout  (selF)
	);

	mops_sync #(.W(6)) u_pinSync (
		.clk   (clk),
		.rst_n (rst_n),
		.din   ({overrideRequestInput, indexPulse, limitSensor, homeSensor, channelGateInput, runInput}),
		.dout  (pinF)
	);

	mops_home u_home (
		.clk         (clk),
		.rst_n       (rst_n),
		.start       (homeStart),
		.mode        (homeMode),
		.homeSensor  (pinF[2]),
		.limitSensor (pinF[3]),
		.indexPulse  (pinF[4]),
		.pos         (position),
		.busy        (homeBusy),
		.done        (homeDone),
		.err         (homeErr),
		.moveReq     (homeMoveReq),
		.moveDir     (homeMoveDir),
		.homePos     (homePos)
	);

	// axi write channels, address and data taken in either order
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			awHeld       <= 1'b0;
			awAddrQ      <= 8'h00;
			wHeld        <= 1'b0;
			wDataQ       <= 32'h0000_0000;
			wStrbQ       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end
		else
		begin
			if (s_axi_awvalid & s_axi_awready)
			begin
				awHeld  <= 1'b1;
				awAddrQ <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready)
			begin
				wHeld  <= 1'b1;
				wDataQ <= s_axi_wdata;
				wStrbQ <= s_axi_wstrb;
			end
			if (doWrite)
			begin
				awHeld       <= 1'b0;
				wHeld        <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awAddrQ > `MOPS_A_HOME || awAddrQ[1:0] != 2'h0) ? 2'h2 : 2'h0;
			end
			else if (s_axi_bvalid & s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// register writes and teach
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			seqOpt       <= `MOPS_SEQ_STOP;
			forceEn      <= 8'h00;
			forceVal     <= 8'h00;
			homeMode     <= `MOPS_RST_HMODE;
			homeStart    <= 1'b0;
			limStart     <= `MOPS_RST_LIM;
			limEnd       <= `MOPS_RST_LIM;
			ovrRatio     <= `MOPS_RST_OVR;
			teachRefused <= 1'b0;
		end
		else
		begin
			homeStart <= 1'b0;
			if (doWrite)
			begin
				case (awAddrQ)
					`MOPS_A_SEQ:
						if (wStrbQ[0] && wDataQ[1:0] != 2'h3)
							seqOpt <= wDataQ[1:0];
					`MOPS_A_FORCE:
					begin
						// bit n of bytes 0 and 1 is output n; mask 0 means X
						if (wStrbQ[1] & wStrbQ[0])
						begin
							forceEn  <= ((wStrbQ[2] & wDataQ[`MOPS_F_RELEASE]) ? 8'h00 : forceEn)
							            | wDataQ[15:8];
							forceVal <= (forceVal & ~wDataQ[15:8]) | (wDataQ[7:0] & wDataQ[15:8]);
						end
						else if (wStrbQ[2] & wDataQ[`MOPS_F_RELEASE])
							forceEn <= 8'h00;
					end
					`MOPS_A_HMODE:
						if (wStrbQ[0])
							homeMode <= wDataQ[2:0];
					`MOPS_A_HCTRL:
						homeStart <= wStrbQ[0] & wDataQ[0];
					`MOPS_A_OTP:
						if (mergeOtp <= {10'h000, `MOPS_LIM_MAX})
							limStart <= mergeOtp[21:0];
					`MOPS_A_LEND:
						if (mergeEnd <= {10'h000, `MOPS_LIM_MAX})
							limEnd <= mergeEnd[21:0];
					`MOPS_A_OVR:
						if (mergeOvr[15:0] <= `MOPS_OVR_MAX && mergeOvr[31:16] == 16'h0000)
							ovrRatio <= mergeOvr[15:0];
					default:
						homeStart <= 1'b0;
				endcase
			end
			// teach start (bit 0) and end (bit 1) from measured position
			if (wrTeach & (wDataQ[0] | wDataQ[1]))
			begin
				if (alarmAny)
					teachRefused <= 1'b1;
				else
				begin
					teachRefused <= 1'b0;
					if (wDataQ[0] && position <= `MOPS_LIM_MAX)
						limStart <= position;
					if (wDataQ[1] && position <= `MOPS_LIM_MAX)
						limEnd <= position;
				end
			end
		end
	end

	// axi read channel, one cycle after the address is taken
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= 2'h0;
		end
		else if (s_axi_arvalid & s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= 2'h0;
			case (s_axi_araddr)
				`MOPS_A_SEQ:   s_axi_rdata <= {30'h0000_0000, seqOpt};
				`MOPS_A_FORCE: s_axi_rdata <= {16'h0000, forceEn, forceVal};
				`MOPS_A_HMODE: s_axi_rdata <= {29'h0000_0000, homeMode};
				`MOPS_A_HCTRL: s_axi_rdata <= {29'h0000_0000, homeErr, homeDone, homeBusy};
				`MOPS_A_OTP:   s_axi_rdata <= {10'h000, limStart};
				`MOPS_A_LEND:  s_axi_rdata <= {10'h000, limEnd};
				`MOPS_A_TEACH: s_axi_rdata <= {31'h0000_0000, teachRefused};
				`MOPS_A_OVR:   s_axi_rdata <= {16'h0000, ovrRatio};
				`MOPS_A_STAT:  s_axi_rdata <= {16'h0000, progChan, 1'b0, ovrF, teachRefused,
				                               softLimitHit, homeErr, homeDone, homeBusy, progActive};
				`MOPS_A_POS:   s_axi_rdata <= {10'h000, position};
				`MOPS_A_HOME:  s_axi_rdata <= {10'h000, homePos};
				default:
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'h2;
				end
			endcase
		end
		else if (s_axi_rvalid & s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// program channel sequencing
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			runPrev     <= 1'b0;
			progStart   <= 1'b0;
			progChan    <= 8'h00;
			progActive  <= 1'b0;
			stepPending <= 1'b0;
		end
		else
		begin
			runPrev   <= runF;
			progStart <= 1'b0;
			if (progActive & chanDone)
			begin
				case (seqOpt)
					`MOPS_SEQ_CONT:
					begin
						progChan  <= progChan + 8'h01;
						progStart <= 1'b1;
					end
					`MOPS_SEQ_STEP:
					begin
						progActive  <= 1'b0;
						stepPending <= 1'b1;
					end
					default:
						progActive <= 1'b0;
				endcase
			end
			else if (~progActive & runF & ~runPrev)
			begin
				progActive  <= 1'b1;
				progStart   <= 1'b1;
				stepPending <= 1'b0;
				if (seqOpt == `MOPS_SEQ_STEP && stepPending)
					progChan <= progChan + 8'h01;
				else if (seqOpt != `MOPS_SEQ_STEP && gateF)
					progChan <= selF;
				else if (seqOpt == `MOPS_SEQ_STEP && !stepPending)
					progChan <= selF;
			end
		end
	end

	// output forcing, soft limit window and override
	wire [30:0] ovrProd = cmdVel * ovrRatio;
	wire [44:0] ovrScaled = ovrProd * `MOPS_OVR_RECIP;
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			generalOutput  <= 8'h00;
			fieldbusOutput <= 8'h00;
			softLimitHit   <= 1'b0;
			velOut         <= 17'h0_0000;
		end
		else
		begin
			generalOutput  <= (forceEn & forceVal) | (~forceEn & funcOut);
			fieldbusOutput <= (forceEn & forceVal) | (~forceEn & busFuncOut);
			if (limStart <= limEnd)
				softLimitHit <= (position >= limStart) & (position <= limEnd);
			else
				softLimitHit <= (position >= limStart) | (position <= limEnd);
			if (ovrF)
				velOut <= ovrScaled[`MOPS_OVR_SHIFT+16:`MOPS_OVR_SHIFT];
			else
				velOut <= {1'b0, cmdVel};
		end
	end
endmodule // mops_top

// file: common/mops_map.vh
`ifndef MOPS_MAP_VH
`define MOPS_MAP_VH
// register byte offsets on the axi4-lite port
`define MOPS_A_SEQ      8'h00
`define MOPS_A_FORCE    8'h04
`define MOPS_A_HMODE    8'h08
`define MOPS_A_HCTRL    8'h0c
`define MOPS_A_OTP      8'h10
`define MOPS_A_LEND     8'h14
`define MOPS_A_TEACH    8'h18
`define MOPS_A_OVR      8'h1c
`define MOPS_A_STAT     8'h20
`define MOPS_A_POS      8'h24
`define MOPS_A_HOME     8'h28
// program sequence option codes
`define MOPS_SEQ_STOP   2'h0
`define MOPS_SEQ_STEP   2'h1
`define MOPS_SEQ_CONT   2'h2
// home mode codes
`define MOPS_HM_LEAVE   3'h1
`define MOPS_HM_LVIDX   3'h3
`define MOPS_HM_ENIDX   3'h4
`define MOPS_HM_ENTER   3'h5
`define MOPS_HM_HERE    3'h6
`define MOPS_HM_LIMIT   3'h7
// reset values
`define MOPS_RST_HMODE  3'h6
`define MOPS_RST_OVR    16'h2710
`define MOPS_RST_LIM    22'h00_0000
// ranges and field positions
`define MOPS_LIM_MAX    22'h27_ffff
`define MOPS_OVR_MAX    16'h4e20
`define MOPS_F_RELEASE  16
// override scaling: ratio in 0.01 percent, 2^27/10000
`define MOPS_OVR_RECIP  14'h346e
`define MOPS_OVR_SHIFT  27
`endif

// file: rtl/mops_sync.v
`timescale 1ns/1ps
// three-stage input filter; output moves when stages two and three agree
module mops_sync #(
	parameter W = 1
) (
	input  wire         clk,
	input  wire         rst_n,
	input  wire [W-1:0] din,
	output reg  [W-1:0] dout
);
	reg [W-1:0] s1; // first stage, read only by s2
	reg [W-1:0] s2; // second stage
	reg [W-1:0] s3; // third stage
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1)
		begin : g_bit
			// per-bit chain and agreement filter
			always @(posedge clk)
			begin
				if (!rst_n)
				begin
					s1[i]   <= 1'b0;
					s2[i]   <= 1'b0;
					s3[i]   <= 1'b0;
					dout[i] <= 1'b0;
				end
				else
				begin
					s1[i] <= din[i];
					s2[i] <= s1[i];
					s3[i] <= s2[i];
					if (s2[i] == s3[i])
						dout[i] <= s3[i];
				end
			end
		end
	endgenerate
endmodule // mops_sync

// file: rtl/mops_home.v
`timescale 1ns/1ps
`include "mops_map.vh"
// home return sequencer
module mops_home (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        start,
	input  wire [2:0]  mode,
	input  wire        homeSensor,
	input  wire        limitSensor,
	input  wire        indexPulse,
	input  wire [21:0] pos,
	output reg         busy,
	output reg         done,
	output reg         err,
	output reg         moveReq,
	output reg         moveDir,
	output reg  [21:0] homePos
);
	localparam S_IDLE = 3'd0;
	localparam S_ON   = 3'd1;
	localparam S_OFF  = 3'd2;
	localparam S_IDX  = 3'd3;
	localparam S_LIM  = 3'd4;
	reg  [2:0] state;     // sequencer state
	reg  [2:0] modeQ;     // mode latched at start
	reg        hsPrev;    // previous home sensor level
	reg        ixPrev;    // previous index level
	wire       hsRise = homeSensor & ~hsPrev;
	wire       hsFall = ~homeSensor & hsPrev;
	wire       ixRise = indexPulse & ~ixPrev;
	// state machine; home position captured from live position
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			state   <= S_IDLE;
			modeQ   <= `MOPS_RST_HMODE;
			hsPrev  <= 1'b0;
			ixPrev  <= 1'b0;
			busy    <= 1'b0;
			done    <= 1'b0;
			err     <= 1'b0;
			moveReq <= 1'b0;
			moveDir <= 1'b0;
			homePos <= 22'h00_0000;
		end
		else
		begin
			hsPrev <= homeSensor;
			ixPrev <= indexPulse;
			case (state)
				S_IDLE:
				begin
					if (start)
					begin
						modeQ   <= mode;
						done    <= 1'b0;
						err     <= 1'b0;
						moveDir <= 1'b0;
						case (mode)
							`MOPS_HM_HERE:
							begin
								homePos <= pos;
								done    <= 1'b1;
							end
							`MOPS_HM_LIMIT:
							begin
								state   <= S_LIM;
								busy    <= 1'b1;
								moveReq <= 1'b1;
							end
							`MOPS_HM_LEAVE, `MOPS_HM_LVIDX, `MOPS_HM_ENIDX, `MOPS_HM_ENTER:
							begin
								state   <= S_ON;
								busy    <= 1'b1;
								moveReq <= 1'b1;
							end
							default:
								err <= 1'b1; // undefined mode refused
						endcase
					end
				end
				S_ON:
				begin
					// wait for entry into sensor area
					if (hsRise)
					begin
						case (modeQ)
							`MOPS_HM_ENTER:
							begin
								homePos <= pos;
								state   <= S_IDLE;
								busy    <= 1'b0;
								moveReq <= 1'b0;
								done    <= 1'b1;
							end
							`MOPS_HM_ENIDX:
								state <= S_IDX;
							default:
								state <= S_OFF;
						endcase
					end
				end
				S_OFF:
				begin
					// wait for leaving the sensor area
					if (hsFall)
					begin
						if (modeQ == `MOPS_HM_LEAVE)
						begin
							homePos <= pos;
							state   <= S_IDLE;
							busy    <= 1'b0;
							moveReq <= 1'b0;
							done    <= 1'b1;
						end
						else
							state <= S_IDX;
					end
				end
				S_LIM:
				begin
					// reverse once the limit sensor is reached
					if (limitSensor)
					begin
						moveDir <= 1'b1;
						state   <= S_IDX;
					end
				end
				S_IDX:
				begin
					// first index edge sets home
					if (ixRise)
					begin
						homePos <= pos;
						state   <= S_IDLE;
						busy    <= 1'b0;
						moveReq <= 1'b0;
						done    <= 1'b1;
					end
				end
				default:
					state <= S_IDLE;
			endcase
		end
	end
endmodule // mops_home

// file: verif/mops_chk.sv
`timescale 1ns/1ps
// port-level checks on bus handshakes, sequencing and override
module mops_chk (
	input logic        clk,
	input logic        rst_n,
	input logic        s_axi_awvalid,
	input logic        s_axi_awready,
	input logic        s_axi_wvalid,
	input logic        s_axi_wready,
	input logic        s_axi_bvalid,
	input logic        s_axi_arvalid,
	input logic        s_axi_arready,
	input logic        s_axi_rvalid,
	input logic        s_axi_rready,
	input logic        chanDone,
	input logic        progStart,
	input logic        progActive,
	input logic [7:0]  progChan,
	input logic        overrideRequestInput,
	input logic [15:0] cmdVel,
	input logic [16:0] velOut
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// both write halves taken at one edge
	sequence s_wtake;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// override pin quiet long enough to pass the filter
	sequence s_ovr_off;
		(!overrideRequestInput) [*6];
	endsequence
	// halves are registered first, the response follows one edge later
	property p_bresp; s_wtake |-> ##2 s_axi_bvalid; endproperty
	property p_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	property p_rone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
	property p_start; $rose(progActive) |-> progStart; endproperty
	property p_stop; $fell(progActive) |-> $past(chanDone); endproperty
	property p_chan; !$stable(progChan) |-> progStart; endproperty
	property p_vel; s_ovr_off |=> velOut == {1'b0, $past(cmdVel)}; endproperty
	a_bresp: assert property (p_bresp) else $error("write response late");
	a_block: assert property (p_block) else $error("ready while response pending");
	a_rans: assert property (p_rans) else $error("read answer late");
	a_rone: assert property (p_rone) else $error("read answer held too long");
	a_start: assert property (p_start) else $error("active without start");
	a_stop: assert property (p_stop) else $error("stop without channel done");
	a_chan: assert property (p_chan) else $error("channel moved without start");
	a_vel: assert property (p_vel) else $error("velocity scaled while idle");
endmodule // mops_chk

bind mops_top mops_chk i_chk (.*);

// file: verif/mops_host.sv
`timescale 1ns/1ps
// host controller model speaking axi4-lite
module mops_host (
	input  logic        clk,
	output logic [7:0]  s_axi_awaddr,
	output logic [2:0]  s_axi_awprot,
	output logic        s_axi_awvalid,
	input  logic        s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0]  s_axi_wstrb,
	output logic        s_axi_wvalid,
	input  logic        s_axi_wready,
	input  logic [1:0]  s_axi_bresp,
	input  logic        s_axi_bvalid,
	output logic        s_axi_bready,
	output logic [7:0]  s_axi_araddr,
	output logic [2:0]  s_axi_arprot,
	output logic        s_axi_arvalid,
	input  logic        s_axi_arready,
	input  logic [31:0] s_axi_rdata,
	input  logic [1:0]  s_axi_rresp,
	input  logic        s_axi_rvalid,
	output logic        s_axi_rready
);
	// idle bus at time zero
	initial
	begin
		{s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata} = '0;
		{s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arprot} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
	end
	// one write; released payload shows the inverse value
	task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic pa;
		logic pw;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d; // digits ordered 7 down to 0
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		while (pa || pw)
		begin
			@(posedge clk);
			if (pa && s_axi_awready)
			begin
				pa = 1'b0;
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (pw && s_axi_wready)
			begin
				pw = 1'b0;
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
			end
		end
		while (!s_axi_bvalid) @(posedge clk);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	// one read
	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		s_axi_araddr <= ~a;
		while (!s_axi_rvalid) @(posedge clk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
endmodule // mops_host

// file: verif/mops_top_tb.sv
`timescale 1ns/1ps
`include "mops_map.vh"
// self-checking bench for the parameter-set block
module mops_top_tb;
	logic clk, rst_n, runInput, channelGateInput, chanDone, progStart, progActive;
	logic [7:0] s_axi_awaddr, s_axi_araddr, progSelect, progChan, funcOut, busFuncOut;
	logic [7:0] generalOutput, fieldbusOutput;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic homeSensor, limitSensor, indexPulse, homeMoveReq, homeMoveDir, softLimitHit;
	logic sensorFaultAlarm, absolutePositionAlarm, overspeedAlarm, overrideRequestInput;
	logic [21:0] position;
	logic [15:0] cmdVel;
	logic [16:0] velOut;
	int numErrors = 0;
	int samplesChecked = 0;
	int cycles = 0;
	int i;
	mops_top i_dut (.*);
	mops_host i_host (.*);
	// 200 mhz clock
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// hang guard
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			numErrors = numErrors + 1;
			print_verdict;
		end
	end
	task print_verdict;
		$display("checks %0d errors %0d", samplesChecked, numErrors);
		if (numErrors == 0 && samplesChecked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samplesChecked = samplesChecked + 1;
		if (got !== exp)
		begin
			numErrors = numErrors + 1;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task cyc(input int n); repeat (n) @(posedge clk); endtask
	task w(input logic [7:0] a, input logic [31:0] d); i_host.wr(a, d, rs); chk(rs, 0); endtask
	task rr(input logic [7:0] a, input logic [31:0] e); i_host.rd(a, rdat, rs); chk(rdat, e); endtask
	task wst; for (i = 0; i < 20 && progStart !== 1'b1; i++) @(posedge clk); endtask
	task run(input logic [7:0] e); runInput <= 1; wst; chk(progChan, e); runInput <= 0; cyc(6); endtask
	task done; chanDone <= 1; cyc(1); chanDone <= 0; cyc(3); endtask
	task t_regs;
		rr(`MOPS_A_HMODE, 32'h0000_0006);
		rr(`MOPS_A_OVR, 32'h0000_2710);
		rr(`MOPS_A_SEQ, 32'h0000_0000);
		i_host.rd(8'h3c, rdat, rs);
		chk(rs, 2);
		$display("t_regs done");
	endtask
	task t_force;
		w(`MOPS_A_FORCE, 32'h0000_ffa5);
		cyc(2);
		chk(generalOutput, 8'ha5);
		chk(fieldbusOutput, 8'ha5);
		w(`MOPS_A_FORCE, 32'h0000_0f00);
		cyc(2);
		chk(generalOutput, 8'ha0);
		w(`MOPS_A_FORCE, 32'h0001_0000);
		cyc(2);
		chk(generalOutput, 8'h3c);
		chk(fieldbusOutput, 8'hc3);
		$display("t_force done");
	endtask
	task t_home(input logic [2:0] m, input logic [21:0] e);
		position <= 100;
		cyc(8);
		w(`MOPS_A_HMODE, m);
		w(`MOPS_A_HCTRL, 1);
		cyc(3);
		chk(homeMoveReq, m != 3'h6);
		chk(homeMoveDir, 0);
		homeSensor <= 1;
		cyc(8);
		position <= 200;
		indexPulse <= 1;
		cyc(8);
		indexPulse <= 0;
		cyc(8);
		position <= 300;
		homeSensor <= 0;
		cyc(8);
		position <= 400;
		indexPulse <= 1;
		cyc(8);
		indexPulse <= 0;
		cyc(4);
		rr(`MOPS_A_HOME, e);
		i_host.rd(`MOPS_A_HCTRL, rdat, rs);
		chk(rdat[1], 1);
		$display("t_home done");
	endtask
	task t_homeLim;
		position <= 50;
		w(`MOPS_A_HMODE, 7);
		w(`MOPS_A_HCTRL, 1);
		cyc(3);
		chk(homeMoveReq, 1);
		chk(homeMoveDir, 0);
		indexPulse <= 1;
		cyc(8);
		indexPulse <= 0;
		cyc(8);
		limitSensor <= 1;
		cyc(8);
		chk(homeMoveDir, 1);
		chk(homeMoveReq, 1);
		limitSensor <= 0;
		position <= 60;
		indexPulse <= 1;
		cyc(8);
		indexPulse <= 0;
		cyc(4);
		rr(`MOPS_A_HOME, 60);
		chk(homeMoveReq, 0);
		$display("t_homeLim done");
	endtask
	task t_lim;
		w(`MOPS_A_OTP, 32'h0027_ffff);
		w(`MOPS_A_OTP, 32'h0028_0000);
		rr(`MOPS_A_OTP, 32'h0027_ffff);
		w(`MOPS_A_OTP, 10);
		w(`MOPS_A_LEND, 20);
		position <= 15;
		cyc(3);
		chk(softLimitHit, 1);
		w(`MOPS_A_OTP, 20);
		w(`MOPS_A_LEND, 10);
		cyc(3);
		chk(softLimitHit, 0);
		position <= 5;
		cyc(3);
		chk(softLimitHit, 1);
		position <= 22'h00_1234;
		w(`MOPS_A_TEACH, 1);
		rr(`MOPS_A_OTP, 32'h0000_1234);
		for (int k = 0; k < 3; k++)
		begin
			{sensorFaultAlarm, absolutePositionAlarm, overspeedAlarm} <= 3'b001 << k;
			cyc(2);
			w(`MOPS_A_TEACH, 2);
			rr(`MOPS_A_LEND, 10);
			rr(`MOPS_A_TEACH, 1);
		end
		{sensorFaultAlarm, absolutePositionAlarm, overspeedAlarm} <= 3'b000;
		$display("t_lim done");
	endtask
	task t_prog;
		progSelect <= 5;
		channelGateInput <= 1;
		run(5);
		done;
		chk(progActive, 0);
		w(`MOPS_A_SEQ, 1);
		progSelect <= 9;
		run(9);
		done;
		chk(progActive, 0);
		channelGateInput <= 0;
		progSelect <= 3;
		run(10);
		done;
		chk(progActive, 0);
		w(`MOPS_A_SEQ, 2);
		run(10);
		chanDone <= 1;
		cyc(1);
		chanDone <= 0;
		wst;
		chk(progChan, 11);
		chk(progActive, 1);
		w(`MOPS_A_SEQ, 0);
		done;
		chk(progActive, 0);
		$display("t_prog done");
	endtask
	task t_ovr;
		cmdVel <= 16'h03e8;
		overrideRequestInput <= 1;
		w(`MOPS_A_OVR, 5000);
		cyc(3);
		chk(velOut, 500);
		w(`MOPS_A_OVR, 20000);
		cyc(3);
		chk(velOut, 2000);
		w(`MOPS_A_OVR, 0);
		cyc(3);
		chk(velOut, 0);
		w(`MOPS_A_OVR, 20001);
		rr(`MOPS_A_OVR, 0);
		overrideRequestInput <= 0;
		cyc(8);
		chk(velOut, 1000);
		$display("t_ovr done");
	endtask
	// main sequence
	initial
	begin
		{rst_n, runInput, channelGateInput, chanDone, progSelect, homeSensor} = '0;
		{limitSensor, indexPulse, position, cmdVel, overrideRequestInput} = '0;
		{sensorFaultAlarm, absolutePositionAlarm, overspeedAlarm} = '0;
		funcOut = 8'h3c;
		busFuncOut = 8'hc3;
		repeat (4) @(posedge clk);
		rst_n <= 1;
		t_regs;
		t_force;
		t_home(3'h6, 100);
		t_home(3'h5, 100);
		t_home(3'h4, 200);
		t_home(3'h1, 300);
		t_home(3'h3, 400);
		t_homeLim;
		t_lim;
		t_prog;
		t_ovr;
		print_verdict;
	end
endmodule // mops_top_tb
